//--- mode_latch_cfg.svh
// offsets, field positions, reset values and vector bases of the mode latch
`ifndef MODE_LATCH_CFG_SVH
`define MODE_LATCH_CFG_SVH

`define ML_ADDR_W 8
`define ML_DATA_W 8

`define ML_OFS_PRIO_MODE 8'h00
`define ML_OFS_PRIV_CTRL 8'h01
`define ML_OFS_STATUS 8'h02

`define ML_BIT_SPECIAL 7
`define ML_BIT_MODE_A 6
`define ML_PRIO_SEL_W 4
`define ML_PRIO_SEL_RST 4'h5

`define ML_BIT_RST_BLOCK 3
`define ML_PRIV_RST_NORMAL 8'h00
`define ML_PRIV_RST_SPECIAL 8'h08

`define ML_ST_BIT_REFUSED 7
`define ML_ST_BIT_VALID 6
`define ML_ST_BIT_PIN_A 5
`define ML_ST_BIT_PIN_B 4

`define ML_VEC_NORMAL 16'hfffe
`define ML_VEC_BOOT 16'hbf40
`define ML_VEC_TEST 16'hbffe

`endif

//--- mode_latch_pkg.sv
// types shared by the operating mode latch
package mode_latch_pkg;

  typedef enum logic [3:0] {
    MODE_SINGLE = 4'h1,
    MODE_EXPANDED = 4'h2,
    MODE_BOOT = 4'h4,
    MODE_TEST = 4'h8
  } op_mode_e;

  typedef enum logic [1:0] {
    ST_HOLD = 2'h1,
    ST_RUN = 2'h2
  } load_state_e;

endpackage

//--- operating_mode_select_latch.sv
// operating mode select latch with its privileged control and register port
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "mode_latch_cfg.svh"

module operating_mode_select_latch
  import mode_latch_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_mode_pin_a,
  input wire logic i_mode_pin_b,
  input wire logic [`ML_ADDR_W-1:0] i_addr,
  input wire logic [`ML_DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`ML_DATA_W-1:0] o_rd_data,
  output logic o_mode_valid,
  output logic [3:0] o_mode,
  output logic o_special,
  output logic o_ext_bus_en,
  output logic o_full_addr_en,
  output logic o_rw_hold_read,
  output logic o_boot_vectors,
  output logic o_test_en,
  output logic [15:0] o_vector_base,
  output logic [`ML_DATA_W-1:0] o_priv_ctrl
);

  // mode from the two flags
  function automatic op_mode_e flags_to_mode(input logic special, input logic mode_a);
    op_mode_e m;
    m = MODE_SINGLE;
    unique case ({special, mode_a})
      2'b00: m = MODE_SINGLE;
      2'b01: m = MODE_EXPANDED;
      2'b10: m = MODE_BOOT;
      2'b11: m = MODE_TEST;
    endcase
    return m;
  endfunction

  // flags from the captured pin pair: special is pin b low, mode-a select is pin a
  function automatic logic [1:0] pins_to_flags(input logic pin_a, input logic pin_b);
    return {~pin_b, pin_a};
  endfunction

  // modes that run the external bus: expanded and test
  function automatic logic bus_mode(input op_mode_e m);
    return (m == MODE_EXPANDED) || (m == MODE_TEST);
  endfunction

  logic pin_a_cap_q;
  logic pin_b_cap_q;
  load_state_e state_q;
  logic special_mode_flag_q;
  logic special_mode_flag_d;
  logic mode_a_select_flag_q;
  logic mode_a_select_flag_d;
  logic [`ML_PRIO_SEL_W-1:0] prio_sel_q;
  logic [`ML_DATA_W-1:0] priv_ctrl_q;
  logic refused_q;
  logic refused_set;
  logic latched_pin_a_q;
  logic latched_pin_b_q;
  logic load_now;
  logic wr_prio;
  logic wr_priv;
  logic wr_status;
  op_mode_e cur_mode;
  logic [`ML_DATA_W-1:0] prio_rd;
  logic [`ML_DATA_W-1:0] priv_rd;
  logic [`ML_DATA_W-1:0] status_rd;
  logic [1:0] cap_flags;
  logic boot_mode;
  logic test_mode;

  assign load_now = (state_q == ST_HOLD);
  assign wr_prio = i_wr && (i_addr == `ML_OFS_PRIO_MODE);
  assign wr_priv = i_wr && (i_addr == `ML_OFS_PRIV_CTRL);
  assign wr_status = i_wr && (i_addr == `ML_OFS_STATUS);
  assign cur_mode = flags_to_mode(special_mode_flag_q, mode_a_select_flag_q);
  assign boot_mode = (cur_mode == MODE_BOOT);
  assign test_mode = (cur_mode == MODE_TEST);

  // decoded once from the capture flops, used in the single load cycle
  assign cap_flags = pins_to_flags(pin_a_cap_q, pin_b_cap_q);

  // pin capture: follows the pins only while reset is held, no reset of its own
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      pin_a_cap_q <= i_mode_pin_a;
      pin_b_cap_q <= i_mode_pin_b;
    end
  end

  // one load cycle after release, then run until the next reset
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_HOLD;
    end else begin
      unique case (state_q)
        ST_HOLD: state_q <= ST_RUN;
        ST_RUN: state_q <= ST_RUN;
      endcase
    end
  end

  // pins as latched, visible in the status register
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      latched_pin_a_q <= 1'b0;
      latched_pin_b_q <= 1'b0;
    end else if (load_now) begin
      latched_pin_a_q <= pin_a_cap_q;
      latched_pin_b_q <= pin_b_cap_q;
    end
  end

  // next value of the special-mode flag
  always_comb begin
    special_mode_flag_d = special_mode_flag_q;
    refused_set = 1'b0;
    // a write in the load cycle loses to the pin load
    if (load_now) begin
      special_mode_flag_d = cap_flags[1];
    end else if (wr_prio) begin
      if (!i_wr_data[`ML_BIT_SPECIAL]) begin
        special_mode_flag_d = 1'b0;
      end else if (!special_mode_flag_q) begin
        refused_set = 1'b1;
      end
    end
  end

  // next value of the mode-a select flag; privileged, so special modes only
  always_comb begin
    mode_a_select_flag_d = mode_a_select_flag_q;
    if (load_now) begin
      mode_a_select_flag_d = cap_flags[0];
    end else if (wr_prio && special_mode_flag_q) begin
      // refused silently while the special flag is low
      mode_a_select_flag_d = i_wr_data[`ML_BIT_MODE_A];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      special_mode_flag_q <= 1'b0;
      mode_a_select_flag_q <= 1'b0;
    end else begin
      special_mode_flag_q <= special_mode_flag_d;
      mode_a_select_flag_q <= mode_a_select_flag_d;
    end
  end

  // ordinary priority select field, writable in any mode
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prio_sel_q <= `ML_PRIO_SEL_RST;
    end else if (wr_prio) begin
      prio_sel_q <= i_wr_data[`ML_PRIO_SEL_W-1:0];
    end
  end

  // privileged control bits; disable-reset bit comes up set in special modes
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      priv_ctrl_q <= `ML_PRIV_RST_NORMAL;
    end else if (load_now) begin
      if (cap_flags[1]) begin
        priv_ctrl_q <= `ML_PRIV_RST_SPECIAL;
      end else begin
        priv_ctrl_q <= `ML_PRIV_RST_NORMAL;
      end
    end else if (wr_priv && special_mode_flag_q) begin
      priv_ctrl_q <= i_wr_data;
    end else if (!special_mode_flag_q) begin
      // leaving special mode wipes them so nothing leaks into normal use
      priv_ctrl_q <= `ML_PRIV_RST_NORMAL;
    end
  end

  // refused-write flag: sticky, write one to clear, a new refusal wins
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      refused_q <= 1'b0;
    end else if (refused_set) begin
      refused_q <= 1'b1;
    end else if (wr_status && i_wr_data[`ML_ST_BIT_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  // register read views
  always_comb begin
    prio_rd = '0;
    prio_rd[`ML_BIT_SPECIAL] = special_mode_flag_q;
    prio_rd[`ML_BIT_MODE_A] = mode_a_select_flag_q;
    prio_rd[`ML_PRIO_SEL_W-1:0] = prio_sel_q;
  end

  always_comb begin
    priv_rd = '0;
    if (test_mode) begin
      priv_rd = priv_ctrl_q;
    end
  end

  always_comb begin
    status_rd = '0;
    status_rd[`ML_ST_BIT_REFUSED] = refused_q;
    status_rd[`ML_ST_BIT_VALID] = (state_q == ST_RUN);
    status_rd[`ML_ST_BIT_PIN_A] = latched_pin_a_q;
    status_rd[`ML_ST_BIT_PIN_B] = latched_pin_b_q;
    status_rd[3:0] = cur_mode;
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        `ML_OFS_PRIO_MODE: o_rd_data <= prio_rd;
        `ML_OFS_PRIV_CTRL: o_rd_data <= priv_rd;
        `ML_OFS_STATUS: o_rd_data <= status_rd;
        // unmapped offsets read as zero
        default: o_rd_data <= '0;
      endcase
    end else begin
      o_rd_data <= '0;
    end
  end

  // mode outputs follow the flags one cycle later
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mode_valid <= 1'b0;
      o_mode <= MODE_SINGLE;
      o_special <= 1'b0;
    end else begin
      o_mode_valid <= (state_q == ST_RUN);
      o_mode <= cur_mode;
      o_special <= special_mode_flag_q;
    end
  end

  // external bus only in the expanded kinds of mode
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_bus_en <= 1'b0;
      o_full_addr_en <= 1'b0;
      o_rw_hold_read <= 1'b1;
    end else begin
      o_ext_bus_en <= bus_mode(cur_mode);
      o_full_addr_en <= bus_mode(cur_mode);
      o_rw_hold_read <= !bus_mode(cur_mode);
    end
  end

  // vector source and test function enable
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_boot_vectors <= 1'b0;
      o_test_en <= 1'b0;
      o_vector_base <= `ML_VEC_NORMAL;
    end else begin
      o_boot_vectors <= boot_mode;
      o_test_en <= test_mode;
      // test mode takes its vectors over the external bus
      unique case (cur_mode)
        MODE_BOOT: o_vector_base <= `ML_VEC_BOOT;
        MODE_TEST: o_vector_base <= `ML_VEC_TEST;
        default: o_vector_base <= `ML_VEC_NORMAL;
      endcase
    end
  end

  // privileged bits drive their functions only in the special modes, boot and test
  // normal modes always see zero here
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_priv_ctrl <= '0;
    end else if (special_mode_flag_q) begin
      o_priv_ctrl <= priv_ctrl_q;
    end else begin
      o_priv_ctrl <= '0;
    end
  end

endmodule

//--- strap_model.sv
// board strapping for the two mode select pins
`timescale 1ns/1ps
module strap_model (
  input wire logic [1:0] i_code,
  output logic o_pin_a,
  output logic o_pin_b
);
  assign o_pin_a = i_code[1];
  assign o_pin_b = i_code[0];
endmodule

//--- mode_latch_monitor.sv
// concurrent checks on the mode latch ports
`timescale 1ns/1ps
module mode_latch_monitor (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rd_data,
  input wire logic o_mode_valid,
  input wire logic [3:0] o_mode,
  input wire logic o_special,
  input wire logic o_ext_bus_en,
  input wire logic o_full_addr_en,
  input wire logic o_rw_hold_read,
  input wire logic o_boot_vectors,
  input wire logic o_test_en,
  input wire logic [15:0] o_vector_base,
  input wire logic [7:0] o_priv_ctrl
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence quiet_s;
    (o_mode_valid && !i_wr) ##1 (o_mode_valid && !i_wr);
  endsequence
  mode_onehot_a: assert property (o_mode_valid |-> $onehot(o_mode))
    else $error("mode not one-hot");
  special_flag_a: assert property (o_mode_valid |-> o_special == (o_mode[2] | o_mode[3]))
    else $error("special flag disagrees with mode");
  single_bus_a: assert property (o_mode[0] |-> !o_ext_bus_en && o_rw_hold_read)
    else $error("bus driven in single chip");
  full_addr_a: assert property (o_full_addr_en == (o_mode[1] | o_mode[3]))
    else $error("full addressing wrong");
  boot_vector_a: assert property (o_mode[2] |-> o_boot_vectors && o_vector_base == 16'hbf40)
    else $error("boot vectors wrong");
  test_expanded_a: assert property (o_test_en == o_mode[3] && (!o_mode[3] || o_ext_bus_en))
    else $error("test mode wrong");
  priv_locked_a: assert property (!o_special |-> o_priv_ctrl == 8'h00)
    else $error("privileged bits open in normal mode");
  special_rise_a: assert property (o_mode_valid |=> !$rose(o_special))
    else $error("special flag set again");
  pins_ignored_a: assert property (quiet_s |=> $stable(o_mode))
    else $error("mode changed without write");
  read_idle_a: assert property (!i_rd |=> o_rd_data == 8'h00)
    else $error("read data outside read cycle");
endmodule
bind operating_mode_select_latch mode_latch_monitor u_mon (.i_sys_clk(i_sys_clk),
  .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
  .o_mode_valid(o_mode_valid), .o_mode(o_mode), .o_special(o_special),
  .o_ext_bus_en(o_ext_bus_en), .o_full_addr_en(o_full_addr_en),
  .o_rw_hold_read(o_rw_hold_read), .o_boot_vectors(o_boot_vectors),
  .o_test_en(o_test_en), .o_vector_base(o_vector_base), .o_priv_ctrl(o_priv_ctrl));

//--- testbench.sv
// self-checking bench for the mode latch
`timescale 1ns/1ps
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [1:0] code = 2'b01;
  logic pin_a;
  logic pin_b;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rd_data;
  logic [7:0] o_priv_ctrl;
  logic [3:0] o_mode;
  logic o_special;
  logic [15:0] o_vector_base;
  wire logic [5:0] outs;
  logic [5:0] ob [4] = '{6'h26, 6'h24, 6'h39, 6'h38};
  int failures = 0;
  int total_checks = 0;
  logic [3:0] md [4] = '{4'h4, 4'h1, 4'h8, 4'h2};
  logic [15:0] vb [4] = '{16'hbf40, 16'hfffe, 16'hbffe, 16'hfffe};
  strap_model STRAP (.i_code(code), .o_pin_a(pin_a), .o_pin_b(pin_b));
  operating_mode_select_latch DUT (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_mode_pin_a(pin_a), .i_mode_pin_b(pin_b), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_mode_valid(outs[5]), .o_mode(o_mode),
    .o_special(o_special), .o_ext_bus_en(outs[4]), .o_full_addr_en(outs[3]),
    .o_rw_hold_read(outs[2]), .o_boot_vectors(outs[1]), .o_test_en(outs[0]),
    .o_vector_base(o_vector_base),
    .o_priv_ctrl(o_priv_ctrl));
  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic conclude;
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rd_data;
  endtask
  task automatic boot(input logic [1:0] c);
    if (i_nrst) begin
      @(posedge i_sys_clk);
    end
    i_nrst <= 1'b0;
    code <= c;
    repeat (16) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic t_decode;
    logic [7:0] d;
    for (int c = 0; c < 4; c++) begin
      boot(c[1:0]);
      chk({11'h000, o_special, o_mode}, {11'h000, ~c[0], md[c]});
      chk({10'h000, outs}, {10'h000, ob[c]});
      chk(o_vector_base, vb[c]);
      chk({8'h00, o_priv_ctrl}, c[0] ? 16'h0000 : 16'h0008);
      rd(8'h02, d);
      chk({8'h00, d}, {8'h00, 2'b01, c[1:0], md[c]});
      @(posedge i_sys_clk);
      code <= ~c[1:0];
      repeat (4) @(posedge i_sys_clk);
      #1;
      chk({12'h000, o_mode}, {12'h000, md[c]});
    end
  endtask
  task automatic t_program;
    logic [7:0] d;
    boot(2'b10);
    wr(8'h01, 8'h03);
    chk({8'h00, o_priv_ctrl}, 16'h0003);
    rd(8'h01, d);
    chk({8'h00, d}, 16'h0003);
    wr(8'h00, 8'h85);
    chk({11'h000, o_special, o_mode}, 16'h0014);
    rd(8'h01, d);
    chk({8'h00, d}, 16'h0000);
    wr(8'h00, 8'h05);
    chk({11'h000, o_special, o_mode}, 16'h0001);
    chk({8'h00, o_priv_ctrl}, 16'h0000);
    wr(8'h00, 8'hc5);
    chk({11'h000, o_special, o_mode}, 16'h0001);
    rd(8'h02, d);
    chk({15'h0000, d[7]}, 16'h0001);
    wr(8'h02, 8'h80);
    rd(8'h02, d);
    chk({15'h0000, d[7]}, 16'h0000);
    wr(8'h01, 8'hff);
    chk({8'h00, o_priv_ctrl}, 16'h0000);
    rd(8'h10, d);
    chk({8'h00, d}, 16'h0000);
  endtask
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    conclude;
  end
  initial begin
    t_decode;
    t_program;
    conclude;
  end
endmodule
